// File: rtl/adcss_map.svh
// Register offsets, field positions and reset values of the sweep sequencer.
// Assumes an 8-bit byte address on the register port, one word per register.
`ifndef ADCSS_MAP_SVH
`define ADCSS_MAP_SVH
`define ADCSS_OFF_CTRL0 8'h00
`define ADCSS_OFF_CTRL1 8'h04
`define ADCSS_OFF_CTRL2 8'h08
`define ADCSS_OFF_CTRL3 8'h0C
`define ADCSS_OFF_CTRL4 8'h10
`define ADCSS_OFF_STATUS 8'h14
`define ADCSS_OFF_RESULT0 8'h20
`define ADCSS_RESULT_STEP 8'h04
// converter_control_0 fields.
`define ADCSS_RUN_BIT 0
`define ADCSS_TRG_SRC_BIT 1
// converter_control_1 fields.
`define ADCSS_SWEEP_LO_BIT 0
`define ADCSS_SWEEP_HI_BIT 1
`define ADCSS_MODE_BIT 2
// converter_control_2 fields.
`define ADCSS_PGS_LO_BIT 0
`define ADCSS_PGS_HI_BIT 1
`define ADCSS_HW_TRG_BIT 2
// converter_control_3 fields.
`define ADCSS_DMA_EN_BIT 0
// converter_control_4 fields.
`define ADCSS_MPG_LO_BIT 0
`define ADCSS_MPG_HI_BIT 1
// Group codes driven on the channel group output.
`define ADCSS_GRP_MAIN 2'h0
`define ADCSS_GRP_G0 2'h1
`define ADCSS_GRP_G2 2'h2
`define ADCSS_GRP_G15 2'h3
// Reset values and counts.
`define ADCSS_RESULT_RST 10'h000
`define ADCSS_SWEEP_LAST 4'hF
`define ADCSS_PIN_LAST 3'h7
`endif

// File: rtl/adcss_pkg.sv
// Types shared by the sweep sequencer.
// Assumes adcss_map.svh supplies all numeric constants.
package adcss_pkg;
  typedef enum logic {
    ADCSS_PRIO_REPEAT,
    ADCSS_MULTI_SINGLE
  } adcss_mode_t;
  typedef enum logic {
    ADCSS_IDLE,
    ADCSS_CONV
  } adcss_state_t;
endpackage : adcss_pkg

// File: rtl/adcss_sequencer.sv
// Sweep sequencer for an analog-to-digital converter core.
// Assumes a converter core that takes a start pulse with a channel and
// answers with a done pulse and a 10-bit result, all on clk.
`include "adcss_map.svh"

module adcss_sequencer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Start triggers.
  input wire logic ext_trig_in,
  input wire logic hw_trig_in,
  // Converter core.
  output logic conv_start,
  output logic [1:0] conv_group,
  output logic [2:0] conv_pin,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  // Conversion-complete request towards interrupt and DMA logic.
  output logic conv_irq
);

  // Control fields.
  logic run_q;
  logic trg_src_q;
  logic hw_trg_q;
  logic [1:0] sweep_sel_q;
  adcss_pkg::adcss_mode_t mode_q;
  logic [1:0] pgs_q;
  logic dma_en_q;
  logic [1:0] mpg_q;
  // Sequencing state.
  adcss_pkg::adcss_state_t state_q;
  logic phase_q;
  logic [1:0] prio_ptr_q;
  logic [2:0] other_ptr_q;
  logic [3:0] mp_idx_q;
  logic ext_prev_q;
  logic start_q;
  logic irq_q;
  logic [1:0] grp_q;
  logic [2:0] pin_q;
  logic [9:0] result_q [0:7];
  logic [31:0] rdata_q;
  // Decoded events.
  logic wr_c0;
  logic run_set;
  logic ext_fall;
  logic trig;
  logic begin_sweep;
  logic done_ok;
  logic mp_last;
  logic [2:0] prio_last;
  logic [1:0] mp_grp;
  logic to_reg0;

  assign wr_c0 = reg_wr && (reg_addr == `ADCSS_OFF_CTRL0);
  assign run_set = wr_c0 && reg_wdata[`ADCSS_RUN_BIT] && !run_q;
  assign ext_fall = ext_prev_q && !ext_trig_in;
  assign prio_last = {1'b0, sweep_sel_q};
  assign to_reg0 = dma_en_q || (mode_q == adcss_pkg::ADCSS_MULTI_SINGLE);
  assign done_ok = (state_q == adcss_pkg::ADCSS_CONV) && conv_done && run_q;
  assign mp_last = (mp_idx_q == `ADCSS_SWEEP_LAST);

  // Trigger selection: a run write obeys the trigger source written with it,
  // so that arming an external source never fires a software start.
  always_comb begin
    if (run_set) begin
      trig = !reg_wdata[`ADCSS_TRG_SRC_BIT];
    end else if (!trg_src_q) begin
      trig = 1'b0;
    end else if (!hw_trg_q) begin
      trig = ext_fall && run_q;
    end else begin
      trig = hw_trig_in && run_q;
    end
  end

  // A trigger only counts while idle; during a conversion it is dropped.
  assign begin_sweep = trig && (state_q == adcss_pkg::ADCSS_IDLE);

  // Multi-port group code to channel group; codes 00 and 01 give group 15.
  always_comb begin
    case (mpg_q)
      2'b10: mp_grp = `ADCSS_GRP_G0;
      2'b11: mp_grp = `ADCSS_GRP_G2;
      default: mp_grp = `ADCSS_GRP_G15;
    endcase
  end

  // Software-written control fields; hardware clears run at the end of a multi-port sweep.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      trg_src_q <= 1'b0;
      hw_trg_q <= 1'b0;
      sweep_sel_q <= 2'b00;
      mode_q <= adcss_pkg::ADCSS_PRIO_REPEAT;
      pgs_q <= 2'b00;
      dma_en_q <= 1'b0;
      mpg_q <= 2'b00;
    end else begin
      if (wr_c0) begin
        run_q <= reg_wdata[`ADCSS_RUN_BIT];
        trg_src_q <= reg_wdata[`ADCSS_TRG_SRC_BIT];
      end else if (done_ok && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE
                   && mp_last) begin
        run_q <= 1'b0;
      end
      if (reg_wr && reg_addr == `ADCSS_OFF_CTRL1) begin
        sweep_sel_q <= reg_wdata[`ADCSS_SWEEP_HI_BIT:`ADCSS_SWEEP_LO_BIT];
        mode_q <= adcss_pkg::adcss_mode_t'(reg_wdata[`ADCSS_MODE_BIT]);
      end
      if (reg_wr && reg_addr == `ADCSS_OFF_CTRL2) begin
        pgs_q <= reg_wdata[`ADCSS_PGS_HI_BIT:`ADCSS_PGS_LO_BIT];
        hw_trg_q <= reg_wdata[`ADCSS_HW_TRG_BIT];
      end
      if (reg_wr && reg_addr == `ADCSS_OFF_CTRL3) begin
        dma_en_q <= reg_wdata[`ADCSS_DMA_EN_BIT];
      end
      if (reg_wr && reg_addr == `ADCSS_OFF_CTRL4) begin
        mpg_q <= reg_wdata[`ADCSS_MPG_HI_BIT:`ADCSS_MPG_LO_BIT];
      end
    end
  end

  // External trigger history for falling-edge detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= ext_trig_in;
    end
  end

  // Sweep state: idle until triggered, converting until stopped or done.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= adcss_pkg::ADCSS_IDLE;
    end else begin
      case (state_q)
        adcss_pkg::ADCSS_IDLE: begin
          if (begin_sweep) begin
            state_q <= adcss_pkg::ADCSS_CONV;
          end
        end
        adcss_pkg::ADCSS_CONV: begin
          if (!run_q) begin
            state_q <= adcss_pkg::ADCSS_IDLE;
          end else if (conv_done && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE
                       && mp_last) begin
            state_q <= adcss_pkg::ADCSS_IDLE;
          end
        end
        default: state_q <= adcss_pkg::ADCSS_IDLE;
      endcase
    end
  end

  // Channel pointers: interleave in priority mode, count up in multi-port.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
      prio_ptr_q <= 2'b00;
      other_ptr_q <= 3'h1;
      mp_idx_q <= 4'h0;
    end else if (begin_sweep) begin
      phase_q <= 1'b0;
      prio_ptr_q <= 2'b00;
      other_ptr_q <= 3'(prio_last + 3'h1);
      mp_idx_q <= 4'h0;
    end else if (done_ok) begin
      mp_idx_q <= 4'(mp_idx_q + 4'h1);
      phase_q <= !phase_q;
      if (!phase_q) begin
        prio_ptr_q <= ({1'b0, prio_ptr_q} == prio_last) ? 2'b00
                      : 2'(prio_ptr_q + 2'b01);
      end else begin
        other_ptr_q <= (other_ptr_q == `ADCSS_PIN_LAST)
                       ? 3'(prio_last + 3'h1)
                       : 3'(other_ptr_q + 3'h1);
      end
    end
  end

  // Channel and start pulse for each conversion, including the next one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_q <= 1'b0;
      grp_q <= `ADCSS_GRP_MAIN;
      pin_q <= 3'h0;
    end else begin
      start_q <= 1'b0;
      if (begin_sweep) begin
        start_q <= 1'b1;
        pin_q <= 3'h0;
        grp_q <= (mode_q == adcss_pkg::ADCSS_MULTI_SINGLE)
                 ? `ADCSS_GRP_MAIN : pgs_q;
      end else if (done_ok && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE) begin
        if (!mp_last) begin
          start_q <= 1'b1;
          pin_q <= 3'(mp_idx_q + 4'h1);
          grp_q <= mp_idx_q[3] || (mp_idx_q[2:0] == `ADCSS_PIN_LAST)
                   ? mp_grp : `ADCSS_GRP_MAIN;
        end
      end else if (done_ok) begin
        start_q <= 1'b1;
        grp_q <= pgs_q;
        pin_q <= phase_q ? {1'b0, prio_ptr_q} : other_ptr_q;
      end
    end
  end

  // Result storage: per-channel registers or the shared register 0.
  for (genvar j = 0; j < 8; j++) begin : g_result
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        result_q[j] <= `ADCSS_RESULT_RST;
      end else if (done_ok) begin
        if (to_reg0 ? (j == 0) : (pin_q == 3'(j))) begin
          result_q[j] <= conv_result;
        end
      end
    end
  end

  // Conversion-complete request, raised on the same edge as each result stored to the shared register 0.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_ok && to_reg0;
    end
  end

  // Read data, valid in the cycle after the read strobe; others read zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= 32'h0000_0000;
      case (reg_addr)
        `ADCSS_OFF_CTRL0: rdata_q <= {30'h0, trg_src_q, run_q};
        `ADCSS_OFF_CTRL1: rdata_q <= {29'h0, mode_q, sweep_sel_q};
        `ADCSS_OFF_CTRL2: rdata_q <= {29'h0, hw_trg_q, pgs_q};
        `ADCSS_OFF_CTRL3: rdata_q <= {31'h0, dma_en_q};
        `ADCSS_OFF_CTRL4: rdata_q <= {30'h0, mpg_q};
        `ADCSS_OFF_STATUS: rdata_q <= {26'h0, pin_q, grp_q, state_q};
        default: begin
          if (reg_addr[7:5] == 3'b001 && reg_addr[1:0] == 2'b00) begin
            rdata_q <= {22'h0, result_q[reg_addr[4:2]]};
          end
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign conv_start = start_q;
  assign conv_group = grp_q;
  assign conv_pin = pin_q;
  assign conv_irq = irq_q;

  // Checks.
  chk_trig_ignored: assert property (@(posedge clk)
    disable iff (!rst_b)
    (state_q == adcss_pkg::ADCSS_CONV && run_q && !conv_done && trig)
    |=> !start_q)
    else $error("Trigger during conversion started a new one.");
  chk_stop_idle: assert property (@(posedge clk)
    disable iff (!rst_b)
    (wr_c0 && !reg_wdata[`ADCSS_RUN_BIT]) |=> ##1
    state_q == adcss_pkg::ADCSS_IDLE)
    else $error("Clearing run did not stop the sweep.");
  chk_no_irq_prio: assert property (@(posedge clk)
    disable iff (!rst_b)
    (mode_q == adcss_pkg::ADCSS_PRIO_REPEAT && !dma_en_q && $stable(mode_q)
     && $stable(dma_en_q)) |=> !conv_irq)
    else $error("Request raised in priority mode without DMA.");
  chk_irq_each: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && to_reg0) |=> conv_irq)
    else $error("Missing request after a conversion.");
  chk_sw_start: assert property (@(posedge clk)
    disable iff (!rst_b)
    (run_set && !reg_wdata[`ADCSS_TRG_SRC_BIT]
     && state_q == adcss_pkg::ADCSS_IDLE)
    |=> start_q && pin_q == 3'h0)
    else $error("Software start did not start a conversion.");
  chk_ext_start: assert property (@(posedge clk)
    disable iff (!rst_b)
    (trg_src_q && !hw_trg_q && run_q && $fell(ext_trig_in)
     && state_q == adcss_pkg::ADCSS_IDLE) |=> start_q)
    else $error("External falling edge did not start a conversion.");
  chk_prio_slot: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && mode_q == adcss_pkg::ADCSS_PRIO_REPEAT && phase_q)
    |=> start_q && {1'b0, pin_q} <= {1'b0, prio_last})
    else $error("Priority slot converted a non-priority channel.");
  chk_prio_other: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && mode_q == adcss_pkg::ADCSS_PRIO_REPEAT && !phase_q)
    |=> start_q && pin_q > prio_last)
    else $error("Other slot converted a priority channel.");
  chk_mp_second: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE
     && mp_idx_q == 4'h7 && mpg_q == 2'b10)
    |=> start_q && conv_group == `ADCSS_GRP_G0 && conv_pin == 3'h0)
    else $error("Ninth channel is not port group 0 channel 0.");
  chk_mp_irq: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE) |=> conv_irq)
    else $error("Multi-port conversion raised no request.");
  chk_mp_end: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && mode_q == adcss_pkg::ADCSS_MULTI_SINGLE && mp_last)
    |=> !start_q && !run_q && state_q == adcss_pkg::ADCSS_IDLE)
    else $error("Multi-port sweep did not end after sixteen.");
  chk_idle_quiet: assert property (@(posedge clk)
    disable iff (!rst_b)
    (state_q == adcss_pkg::ADCSS_IDLE && !begin_sweep) |=> !start_q)
    else $error("Idle sequencer started a conversion untriggered.");
  chk_result_own: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && !to_reg0)
    |=> result_q[$past(pin_q)] == $past(conv_result))
    else $error("Result missing from its channel register.");
  chk_result_zero: assert property (@(posedge clk)
    disable iff (!rst_b)
    (done_ok && to_reg0) |=> result_q[0] == $past(conv_result))
    else $error("Result missing from result register 0.");

endmodule : adcss_sequencer

// File: dv/adcss_conv_model.sv
// Converter core model: answers each start after a set latency.
// Assumes one conversion at a time; a new start restarts the count.
module adcss_conv_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Start side.
  input wire logic conv_start,
  input wire logic [1:0] conv_group,
  input wire logic [2:0] conv_pin,
  input wire logic [7:0] lat,
  // Answer side.
  output logic conv_done,
  output logic [9:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [7:0] cnt_q;
  logic [9:0] tag_q;
  // Counts the latency down, then pulses done with a channel-coded value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      tag_q <= 10'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
        tag_q <= {3'h5, conv_group, 2'h1, conv_pin};
      end else if (busy_q && cnt_q <= 8'h01) begin
        busy_q <= 1'b0;
        conv_done <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // Outside the done cycle the bus shows the inverse of the last value.
  assign conv_result = conv_done ? tag_q : ~tag_q;
endmodule : adcss_conv_model

// File: dv/adcss_sequencer_bench.sv
// Bench for the sweep sequencer: priority and multi-port sweeps.
// Assumes the converter model and the register map header.
`include "adcss_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module adcss_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, reg_wr, reg_rd, ext_trig_in, hw_trig_in;
  logic conv_start, conv_done, conv_irq;
  logic [7:0] reg_addr, lat;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0] conv_group;
  logic [2:0] conv_pin;
  logic [9:0] conv_result;
  logic [4:0] starts[$];
  int irq_n, cyc, failures, check_count;
  adcss_sequencer dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_trig_in, .hw_trig_in, .conv_start,
    .conv_group, .conv_pin, .conv_done, .conv_result, .conv_irq);
  adcss_conv_model conv_u (.clk, .rst_b, .conv_start, .conv_group,
    .conv_pin, .lat, .conv_done, .conv_result);
  // Free-running clock at 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Records starts and requests, and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (conv_start) starts.push_back({conv_group, conv_pin});
    if (conv_irq) irq_n++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [9:0] res(logic [1:0] g, logic [2:0] p);
    return {3'h5, g, 2'h1, p};
  endfunction : res
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic go(input logic [31:0] c1, c2, c3, c4, c0);
    wr(`ADCSS_OFF_CTRL1, c1);
    wr(`ADCSS_OFF_CTRL2, c2);
    wr(`ADCSS_OFF_CTRL3, c3);
    wr(`ADCSS_OFF_CTRL4, c4);
    starts = {};
    irq_n = 0;
    wr(`ADCSS_OFF_CTRL0, c0);
  endtask : go
  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (starts.size() < n && k < 500) begin
      @(posedge clk);
      k++;
    end
    // A sweep that never delivers its starts counts as a mismatch.
    if (k == 500) failures++;
  endtask : wait_n
  // Priority sweeps with one to four priority channels in group 2.
  task automatic t_prio;
    int p, k, n;
    for (p = 1; p <= 4; p++) begin
      go(p - 1, 32'h2, p % 2 == 0, 0, 1);
      wait_n(12);
      wr(`ADCSS_OFF_CTRL0, 0);
      repeat (8) @(posedge clk);
      n = starts.size();
      repeat (20) @(posedge clk);
      `CHK(starts.size(), n)
      for (k = 0; k < 12; k++) begin
        `CHK(starts[k], {2'h2, 3'(k % 2 ? p + (k / 2) % (8 - p) : (k / 2) % p)})
      end
      if (p % 2 == 0) begin
        `CHK(irq_n + 1 >= n && irq_n <= n, 1'b1)
      end else begin
        `CHK(irq_n, 0)
        rd(`ADCSS_OFF_RESULT0 + 8'(4 * p));
        `CHK(d, {22'h0, res(2'h2, 3'(p))})
      end
    end
    $display("priority sweeps done");
  endtask : t_prio
  // Multi-port single sweeps over every group code.
  task automatic t_multi;
    int c, k;
    logic [1:0] g;
    for (c = 0; c < 4; c++) begin
      g = c == 2 ? `ADCSS_GRP_G0 : c == 3 ? `ADCSS_GRP_G2 : `ADCSS_GRP_G15;
      go(32'h4, 0, 1, c, 1);
      wait_n(16);
      repeat (20) @(posedge clk);
      `CHK(starts.size(), 16)
      `CHK(irq_n, 16)
      for (k = 0; k < 16; k++) begin
        `CHK(starts[k], {k < 8 ? 2'h0 : g, 3'(k % 8)})
      end
      rd(`ADCSS_OFF_RESULT0);
      `CHK(d, {22'h0, res(g, 3'h7)})
      `CHK(d[31:16], 16'h0000)
      rd(`ADCSS_OFF_STATUS);
      `CHK(d[0], 1'b0)
      rd(`ADCSS_OFF_CTRL0);
      `CHK(d[0], 1'b0)
    end
    $display("multi-port sweeps done");
  endtask : t_multi
  // External trigger, trigger during conversion, stop in mid-sweep.
  task automatic t_trig;
    int n;
    lat = 8'd30;
    go(0, 32'h2, 0, 0, 3);
    repeat (6) @(posedge clk);
    `CHK(starts.size(), 0)
    ext_trig_in <= 1'b0;
    repeat (2) @(posedge clk);
    ext_trig_in <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(starts.size(), 1)
    ext_trig_in <= 1'b0;
    repeat (2) @(posedge clk);
    ext_trig_in <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(starts.size(), 1)
    wr(`ADCSS_OFF_CTRL0, 0);
    go(32'h4, 0, 1, 2, 1);
    wait_n(2);
    wr(`ADCSS_OFF_CTRL0, 0);
    n = starts.size();
    repeat (70) @(posedge clk);
    `CHK(starts.size(), n)
    // Hardware trigger source: armed run waits for the trigger pulse.
    lat <= 8'd2;
    go(0, 32'h6, 0, 0, 3);
    repeat (4) @(posedge clk);
    `CHK(starts.size(), 0)
    hw_trig_in <= 1'b1;
    @(posedge clk);
    hw_trig_in <= 1'b0;
    wait_n(3);
    `CHK(starts[2], {2'h2, 3'h0})
    wr(`ADCSS_OFF_CTRL0, 0);
    rd(8'h18);
    `CHK(d, 32'h0000_0000)
    $display("trigger and stop done");
  endtask : t_trig
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Reset for ten cycles, then run every scenario.
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_trig_in = 1'b1;
    hw_trig_in = 1'b0;
    lat = 8'd2;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(`ADCSS_OFF_STATUS);
    `CHK(d, 32'h0000_0000)
    t_prio();
    t_multi();
    t_trig();
    give_verdict();
  end
endmodule : adcss_sequencer_bench
